// *** include/agc_page_params.svh ***
// What this block does
// - the signal debounce field at bits 3..0 gives no debounce at code 0, four samples at code 1, doubling up to code 1000, then 2048 samples at code 1001.
// - debounce codes above 1001 give whole multiples of 2048 samples that grow with the code.
// - the applied-gain status is read-only, two's complement in half-dB steps from -12 dB to +40 dB, and zero after reset.
// - gain codes 0x51 through 0xe7 are never reported, and the host treats them as invalid.
// - reserved addresses 102..127 on page 0 and 1..25 and 27..50 on page 1 are never written.
// - address zero is an 8-bit read-write page selector that resets to page zero.
// - dither bits 7..4 hold the left input offset, signed magnitude in 15 mV steps, reset zero.
// - dither bits 3..0 hold the right input offset in the same form, reset zero.
// - bias bits 4..3 choose off, 2 V, 2.5 V or the analog supply rail, reset off.
// Purpose: addresses, reset values and debounce counts of the register bank
// Assumes: 7-bit register addresses on one page at a time
// Notes:   gain limits are two's complement half-dB codes
`ifndef AGC_PAGE_PARAMS_SVH
`define AGC_PAGE_PARAMS_SVH
`define PAGE_SEL_ADDR    7'h00
`define DBNC_ADDR        7'h64
`define GAIN_ADDR        7'h65
`define DITHER_ADDR      7'h1a
`define BIAS_ADDR        7'h33
`define PAGE_ZERO        8'h00
`define PAGE_ONE         8'h01
`define RESET_BYTE       8'h00
`define GAIN_MAX         8'h50
`define GAIN_MIN         8'he8
`define DBNC_POW_LAST    4'h9
`define DBNC_BASE        16'h0004
`define DBNC_STEP        16'h0800
`define BIAS_LSB         3
`endif

// *** include/agc_page_pkg.sv ***
// Purpose: types shared by the register bank
// Assumes: one register port in the core clock domain
// Notes:   none
package agc_page_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
    typedef enum logic [1:0] {
        BIAS_OFF,
        BIAS_2V0,
        BIAS_2V5,
        BIAS_RAIL
    } bias_level_t;
endpackage

// *** verilog/agc_page_regs.sv ***
// Purpose: paged control registers for right gain debounce, gain status,
//          page selection, input offset dither and second bias level
// Assumes: requests come from the control-bus front end on clk_i
// Notes:   reserved addresses read zero and drop writes
`include "agc_page_params.svh"

module agc_page_regs (
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    input  wire agc_page_pkg::reg_req_t    req_i,
    input  wire logic [7:0]                gain_i,
    output logic      [7:0]                rdata_o,
    output logic                           rvalid_o,
    output logic      [7:0]                page_o,
    output logic      [3:0]                dbnc_code_o,
    output logic      [15:0]               dbnc_samples_o,
    output logic      [7:0]                gain_status_o,
    output logic      [3:0]                left_offset_o,
    output logic      [3:0]                right_offset_o,
    output agc_page_pkg::bias_level_t      second_mic_bias_output_o
);

    // maps a debounce code to a sample count
    function automatic logic [15:0] dbnc_count(input logic [3:0] code);
        logic [15:0] res;
        res = 16'h0000;
        if (code == 4'h0) begin
            res = 16'h0000;
        end else if (code == `DBNC_POW_LAST) begin
            res = `DBNC_STEP;
        end else if (code < `DBNC_POW_LAST) begin
            res = 16'(`DBNC_BASE << (code - 4'h1));
        end else begin
            res = 16'(`DBNC_STEP * 16'(code - 4'h8));
        end
        return res;
    endfunction

    // saturates a gain word into the reportable span
    function automatic logic [7:0] gain_clamp(input logic [7:0] g);
        logic [7:0] res;
        res = g;
        if ($signed(g) > $signed(`GAIN_MAX)) begin
            res = `GAIN_MAX;
        end else if ($signed(g) < $signed(`GAIN_MIN)) begin
            res = `GAIN_MIN;
        end
        return res;
    endfunction

    logic [7:0] page_ff;
    logic [3:0] dbnc_ff;
    logic [15:0] samples_ff;
    logic [7:0] gain_ff;
    logic [7:0] dither_ff;
    logic [1:0] bias_ff;
    logic [7:0] rdata_ff;
    logic       rvalid_ff;

    wire on_p0      = (page_ff == `PAGE_ZERO);
    wire on_p1      = (page_ff == `PAGE_ONE);
    wire hit_page   = (req_i.addr == `PAGE_SEL_ADDR);
    // decode on the current page only
    // page qualified decode
    wire hit_dbnc   = on_p0 && (req_i.addr == `DBNC_ADDR);
    wire hit_gain   = on_p0 && (req_i.addr == `GAIN_ADDR);
    wire hit_dither = on_p1 && (req_i.addr == `DITHER_ADDR);
    wire hit_bias   = on_p1 && (req_i.addr == `BIAS_ADDR);

    wire wr_page    = req_i.wr && hit_page;
    wire wr_dbnc    = req_i.wr && hit_dbnc;
    wire wr_dither  = req_i.wr && hit_dither;
    wire wr_bias    = req_i.wr && hit_bias;

    wire [7:0] nxt_page   = wr_page ? req_i.wdata : page_ff;
    wire [3:0] nxt_dbnc   = wr_dbnc ? req_i.wdata[3:0] : dbnc_ff;
    wire [15:0] nxt_samples = dbnc_count(nxt_dbnc);
    wire [7:0] nxt_gain   = gain_clamp(gain_i);
    wire [7:0] nxt_dither = wr_dither ? req_i.wdata : dither_ff;
    wire [1:0] nxt_bias   = wr_bias ? req_i.wdata[`BIAS_LSB+1:`BIAS_LSB] : bias_ff;

    // reserved bits are rebuilt from constants so a stray write cannot reach them
    // reserved bits read reset value
    wire [7:0] dbnc_rd = {4'h0, dbnc_ff};
    wire [7:0] bias_rd = {3'h0, bias_ff, 3'h0};

    wire [7:0] nxt_rdata =
        !req_i.rd  ? rdata_ff  :
        hit_page   ? page_ff   :
        hit_dbnc   ? dbnc_rd   :
        hit_gain   ? gain_ff   :
        hit_dither ? dither_ff :
        hit_bias   ? bias_rd   : `RESET_BYTE;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            page_ff    <= `PAGE_ZERO;
            dbnc_ff    <= 4'h0;
            samples_ff <= 16'h0000;
            gain_ff    <= `RESET_BYTE;
            dither_ff  <= `RESET_BYTE;
            bias_ff    <= 2'h0;
        end else begin
            page_ff    <= nxt_page;
            dbnc_ff    <= nxt_dbnc;
            samples_ff <= nxt_samples;
            gain_ff    <= nxt_gain;
            dither_ff  <= nxt_dither;
            bias_ff    <= nxt_bias;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_ff  <= `RESET_BYTE;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= req_i.rd;
        end
    end

    assign rdata_o        = rdata_ff;
    assign rvalid_o       = rvalid_ff;
    assign page_o         = page_ff;
    assign dbnc_code_o    = dbnc_ff;
    assign dbnc_samples_o = samples_ff;
    assign gain_status_o  = gain_ff;
    assign left_offset_o  = dither_ff[7:4];
    assign right_offset_o = dither_ff[3:0];
    assign second_mic_bias_output_o = agc_page_pkg::bias_level_t'(bias_ff);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    page_write_a: assert property (
        wr_page |=> page_o == $past(req_i.wdata))
        else $error("page selector did not take written value");

    page_hold_a: assert property (
        !wr_page |=> $stable(page_o))
        else $error("page changed without a selector write");

    page_decode_a: assert property (
        req_i.wr && !hit_page && (page_ff != `PAGE_ONE) |=> $stable(dither_ff) && $stable(bias_ff))
        else $error("page one register written from another page");

    dbnc_count_a: assert property (
        (dbnc_ff == 4'h0 |-> samples_ff == 16'h0000) and
        (dbnc_ff == 4'h1 |-> samples_ff == 16'h0004) and
        (dbnc_ff == 4'h9 |-> samples_ff == 16'h0800))
        else $error("debounce count wrong in power-of-two range");

    dbnc_multiple_a: assert property (
        dbnc_ff > 4'h9 |-> samples_ff[10:0] == 11'h000 &&
            samples_ff[15:11] == 5'(dbnc_ff - 4'h8))
        else $error("debounce count not a multiple of 2048");

    dbnc_upper_a: assert property (
        req_i.rd && hit_dbnc |=> rdata_o[7:4] == 4'h0 && rvalid_o)
        else $error("reserved debounce bits read nonzero");

    gain_range_a: assert property (
        ##1 ($signed(gain_status_o) <= $signed(8'h50) &&
             $signed(gain_status_o) >= $signed(8'he8)))
        else $error("reserved gain code reported");

    gain_track_a: assert property (
        ($signed(gain_i) <= $signed(8'h50) && $signed(gain_i) >= $signed(8'he8))
            |=> gain_status_o == $past(gain_i))
        else $error("gain status does not follow applied gain");

    offset_write_a: assert property (
        wr_dither |=> left_offset_o == $past(req_i.wdata[7:4]) &&
            right_offset_o == $past(req_i.wdata[3:0]))
        else $error("offset fields did not take written value");

    bias_write_a: assert property (
        wr_bias |=> bias_rd == {3'h0, $past(req_i.wdata[4:3]), 3'h0})
        else $error("bias level did not take written value");

    reserved_read_a: assert property (
        req_i.rd && on_p0 && req_i.addr > 7'h65 |=> rdata_o == 8'h00)
        else $error("reserved address read nonzero");

    page_read_a: assert property (
        req_i.rd && hit_page
        |=> rvalid_o && rdata_o == $past(page_ff))
        else $error("page selector read back wrong value");

    gain_read_a: assert property (
        req_i.rd && hit_gain
        |=> rdata_o == $past(gain_ff))
        else $error("gain status read back wrong value");

    dither_read_a: assert property (
        req_i.rd && hit_dither
        |=> rdata_o == $past(dither_ff))
        else $error("offset register read back wrong value");

    bias_read_a: assert property (
        req_i.rd && hit_bias
        |=> rdata_o[4:3] == $past(bias_ff))
        else $error("bias level read back wrong value");

    bias_reserved_a: assert property (
        req_i.rd && hit_bias
        |=> rdata_o[7:5] == 3'h0 && rdata_o[2:0] == 3'h0)
        else $error("reserved bias bits read nonzero");

    dbnc_read_a: assert property (
        req_i.rd && hit_dbnc
        |=> rdata_o[3:0] == $past(dbnc_ff))
        else $error("debounce code read back wrong value");

    rvalid_set_a: assert property (
        req_i.rd
        |=> rvalid_o)
        else $error("read answered without valid");

    rvalid_idle_a: assert property (
        !req_i.rd
        |=> !rvalid_o)
        else $error("valid raised without a read");

    rdata_hold_a: assert property (
        !req_i.rd
        |=> $stable(rdata_o))
        else $error("read data changed without a read");

    dbnc_write_a: assert property (
        wr_dbnc
        |=> dbnc_code_o == $past(req_i.wdata[3:0]))
        else $error("debounce code did not take written value");

    dbnc_hold_a: assert property (
        !wr_dbnc
        |=> $stable(dbnc_code_o))
        else $error("debounce code changed without a write");

    dither_hold_a: assert property (
        !wr_dither
        |=> $stable(dither_ff))
        else $error("offset fields changed without a write");

    bias_hold_a: assert property (
        !wr_bias
        |=> $stable(second_mic_bias_output_o))
        else $error("bias level changed without a write");

    dbnc_page_a: assert property (
        req_i.wr && (page_ff != `PAGE_ZERO)
        |=> $stable(dbnc_ff))
        else $error("page zero register written from another page");

    gain_high_a: assert property (
        $signed(gain_i) > $signed(8'h50)
        |=> gain_status_o == 8'h50)
        else $error("gain above range not held at top code");

    gain_low_a: assert property (
        $signed(gain_i) < $signed(8'he8)
        |=> gain_status_o == 8'he8)
        else $error("gain below range not held at bottom code");

    reserved_p1_a: assert property (
        req_i.rd && on_p1 && !hit_page && !hit_dither && !hit_bias
        |=> rdata_o == 8'h00)
        else $error("reserved page one address read nonzero");

    other_page_a: assert property (
        req_i.rd && !on_p0 && !on_p1 && !hit_page
        |=> rdata_o == 8'h00)
        else $error("undecoded page returned data");

    unmapped_p0_a: assert property (
        req_i.rd && on_p0 && !hit_page && req_i.addr < 7'h64
        |=> rdata_o == 8'h00)
        else $error("unmapped page zero address read nonzero");

    dbnc_mid_a: assert property (
        (dbnc_ff == 4'h5 |-> samples_ff == 16'h0040) and
        (dbnc_ff == 4'h8 |-> samples_ff == 16'h0200))
        else $error("debounce count wrong in middle of power range");

    dbnc_top_a: assert property (
        (dbnc_ff == 4'ha |-> samples_ff == 16'h1000) and
        (dbnc_ff == 4'hf |-> samples_ff == 16'h3800))
        else $error("debounce count wrong in long range");

    bias_code_a: assert property (
        (wr_bias && req_i.wdata[4:3] == 2'h3 |=> second_mic_bias_output_o == agc_page_pkg::BIAS_RAIL) and
        (wr_bias && req_i.wdata[4:3] == 2'h2 |=> second_mic_bias_output_o == agc_page_pkg::BIAS_2V5))
        else $error("bias code mapped to wrong level");

endmodule

// *** verif/host_model.sv ***
// Purpose: host controller model on the register request port
// Assumes: one request at a time, launched just after a rising edge
// Notes:   released address and data show the inverse of the last value
module host_model (
    input  wire logic              clk_i,
    output agc_page_pkg::reg_req_t req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req_o = '0;
    task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

// *** verif/tb_agc_page_regs.sv ***
// Purpose: self-checking bench for the paged register bank
// Assumes: synchronous active-low reset, one clock
// Notes:   reserved places are expected to read zero
module tb_agc_page_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic                      clk_i = 1'b0;
    logic                      rst_n = 1'b0;
    logic [7:0]                gain_in = 8'h00;
    agc_page_pkg::reg_req_t    req;
    logic [7:0]                rdata, page, gst;
    logic                      rvalid;
    logic [3:0]                code, left, right;
    logic [15:0]               samp;
    agc_page_pkg::bias_level_t bias;
    int                        err_count = 0;
    int                        tests_run = 0;
    int                        i;
    logic [7:0] gv [8] = '{8'h00, 8'h50, 8'h51, 8'h7f, 8'he8, 8'he7, 8'h80, 8'hff};
    logic [7:0] ge [8] = '{8'h00, 8'h50, 8'h50, 8'h50, 8'he8, 8'he8, 8'he8, 8'hff};
    host_model u_host (.clk_i(clk_i), .req_o(req));
    agc_page_regs u_dut (.clk_i(clk_i), .rst_n_i(rst_n), .req_i(req), .gain_i(gain_in),
        .rdata_o(rdata), .rvalid_o(rvalid), .page_o(page), .dbnc_code_o(code),
        .dbnc_samples_o(samp), .gain_status_o(gst), .left_offset_o(left),
        .right_offset_o(right), .second_mic_bias_output_o(bias));
    initial forever #2.5 clk_i = ~clk_i;
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_host.xfer(1'b1, a, d);
        #1;
    endtask
    // read answer lands exactly one cycle after the request edge
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        u_host.xfer(1'b0, a, 8'h00);
        #1;
        chk("rvalid", {15'h0, rvalid}, 16'h0001);
        chk("rdata", {8'h0, rdata}, {8'h0, e});
    endtask
    function automatic logic [15:0] dexp(input int c);
        if (c == 0) return 16'h0000;
        if (c <= 8) return 16'h0004 << (c - 1);
        return 16'(16'h0800 * ((c == 9) ? 1 : c - 8));
    endfunction
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // bound far above the roughly 110 cycles the tests need
    initial begin
        #20000;
        err_count++;
        $display("watchdog expired");
        final_report();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_n <= 1'b1;
        #1;
        chk("page", {8'h0, page}, 16'h0000);
        chk("bias", {14'h0, bias}, 16'h0000);
        chk("dither", {8'h0, left, right}, 16'h0000);
        rd(7'h00, 8'h00);
        rd(7'h64, 8'h00);
        rd(7'h65, 8'h00);
        $display("test reset done");
        for (i = 0; i < 16; i++) begin
            wr(7'h64, 8'(i));
            @(posedge clk_i);
            #1;
            chk("dbnc_code", {12'h0, code}, 16'(i));
            chk("dbnc_samples", samp, dexp(i));
        end
        wr(7'h64, 8'hf5);
        rd(7'h64, 8'h05);
        $display("test debounce done");
        for (i = 0; i < 8; i++) begin
            @(posedge clk_i);
            gain_in <= gv[i];
            @(posedge clk_i);
            #1;
            chk("gain_status", {8'h0, gst}, {8'h0, ge[i]});
        end
        wr(7'h65, 8'h12);
        rd(7'h65, 8'hff);
        $display("test gain done");
        wr(7'h00, 8'h01);
        chk("page", {8'h0, page}, 16'h0001);
        rd(7'h64, 8'h00);
        wr(7'h1a, 8'h9f);
        chk("dither", {8'h0, left, right}, 16'h009f);
        rd(7'h1a, 8'h9f);
        for (i = 0; i < 4; i++) begin
            wr(7'h33, 8'(i << 3));
            chk("bias", {14'h0, bias}, 16'(i));
        end
        wr(7'h33, 8'hff);
        rd(7'h33, 8'h18);
        wr(7'h1b, 8'h55);
        rd(7'h1b, 8'h00);
        wr(7'h00, 8'h20);
        chk("page", {8'h0, page}, 16'h0020);
        rd(7'h1a, 8'h00);
        $display("test page done");
        final_report();
    end
endmodule
